// [design/mpac_mmu.sv]
// memory protection, address translation and privilege mode control
// Function
// R1: outside test mode only the upper part of each memory is reachable
// R2: test mode reaches both parts of every memory
// R3: partition split is fixed by constants, software cannot change it
// R4: segment table written only in system mode, checked only in user mode
// R5: each entry holds rights, start, end, offset and peripheral group rights
// R6: up to 64 entries; end marker shortens table, unused entries skip
// R7: read, write and execute rights are granted independently per segment
// R8: offset relocates the segment; result still passes the partition check
// R9: rights for 16 peripheral register groups go to the register checker
// R10: boot, test and system modes show full group rights
// R11: secure-application mode uses two rights registers, locked in that mode
// R12: addresses outside implemented memory raise an exception
// R13: forbidden user-mode access raises an exception
// R14: forbidden register writes are dropped, forbidden reads return a constant
// R15: banked register has user, system and privileged-group copies
// R16: two mode bits, both clear means user mode
// R17: system vector call sets system bit, illegal outside user mode
// R18: config vector call enters secure-application mode unless plain build
// R19: exceptions set system bit; interrupts do so unless run in user mode
// R20: interrupt return restores saved bits; in user mode needs enabled irq
// R21: call to user entry from system mode drops to user mode
// R22: software writes to mode bits can only clear them
// R23: boot only after reset; no way back to boot from other modes
// R24: violating access is suppressed in the cycle its exception is raised
`timescale 1ns/1ns
module mpac_mmu
  import mpac_pkg::*;
#(
  parameter int NSEG       = NSEG_MAX,
  parameter bit PLAIN_CONFIG_ENTRY_VECTOR = 1'b0
) (
  input  wire logic           mclk_i,
  input  wire logic           reset_n_i,
  input  wire logic           ce_i,
  input  wire logic           test_avail_i,
  input  wire logic           boot_done_i,
  input  wire mpac_ev_t       ev_i,
  input  wire mpac_acc_t      acc_i,
  input  wire logic           seg_wr_i,
  input  wire logic [$clog2(NSEG)-1:0] seg_idx_i,
  input  wire mpac_seg_t      seg_data_i,
  input  wire mpac_sfr_t      sfr_i,
  output logic                exc_o,
  output mpac_acc_t           mem_o,
  output logic [NGRP-1:0]     grp_rights_o,
  output logic [1:0]          mode_word_o,
  output mpac_smode_t         super_kind_o,
  output logic [7:0]          sfr_rdata_o,
  output logic                sfr_rvalid_o
);

  // ------------------------------------------------------------
  // elaboration check and state
  // ------------------------------------------------------------
  if (NSEG < 2 || NSEG > NSEG_MAX) begin : g_chk
    $error("segment count out of range");
  end

  typedef struct packed {
    logic                   ssm;
    logic                   sm;
    mpac_smode_t            kind;
    logic [1:0]             sav;
    logic                   irq_act;
    logic                   irq_user;
    logic [15:0]            app_rt;
    logic [2:0][7:0]        bank;
    logic [15:0]            code_rt;
    mpac_seg_t [NSEG-1:0]   tab;
    mpac_acc_t              mem;
    logic                   exc;
    logic [15:0]            grp;
    logic [7:0]             rdata;
    logic                   rvalid;
  } mpac_st_t;

  mpac_st_t    st_ff;
  mpac_st_t    nxt_st;
  mpac_seg_t   hseg;
  logic        user, sysm, appm, test, hit, stop, inb;
  logic        inp, viol, vexc, bt, wok, rok;
  logic [23:0] paddr;
  logic [1:0]  bi;
  logic [7:0]  rval;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic in_rng(logic [23:0] a, logic [23:0] lo, logic [23:0] hi);
    return (a >= lo) && (a < hi);
  endfunction : in_rng

  function automatic logic mem_ok(logic [23:0] a, logic full);
    return in_rng(a, full ? RAM_LO : RAM_MID, RAM_HI) ||
           in_rng(a, full ? EE_LO : EE_MID, EE_HI) ||
           in_rng(a, full ? ROM_LO : ROM_MID, ROM_HI);
  endfunction : mem_ok

  function automatic logic rt_ok(logic [3:0] r, mpac_kind_t k);
    return (k == ACC_RD) ? r[RT_R] : (k == ACC_WR) ? r[RT_W] : (k == ACC_EX) ? r[RT_X] : 1'b0;
  endfunction : rt_ok

  function automatic logic [1:0] bank_idx(logic ssm, logic sm);
    return ssm ? 2'h2 : (sm ? 2'h1 : 2'h0);
  endfunction : bank_idx

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    user = !st_ff.ssm && !st_ff.sm; // [R16]
    sysm = !st_ff.ssm && st_ff.sm;
    appm = st_ff.ssm && (st_ff.kind == SMK_APP);
    test = st_ff.ssm && (st_ff.kind == SMK_TEST);
    bt = boot_done_i && st_ff.ssm && (st_ff.kind == SMK_BOOT);
    vexc = 1'b0;
    // segment lookup, first match wins
    hit = 1'b0;
    stop = 1'b0;
    hseg = '0;
    for (int i = 0; i < NSEG; i++) begin // [R6]
      if (!hit && !stop) begin
        if (st_ff.tab[i].rights[RT_END]) begin
          stop = 1'b1;
        end else if (st_ff.tab[i].rights != RT_UNUSED &&
                     acc_i.addr >= st_ff.tab[i].vstart &&
                     acc_i.addr <= st_ff.tab[i].vend) begin // [R5]
          hit = 1'b1;
          hseg = st_ff.tab[i];
        end
      end
    end
    // translation and checks
    paddr = user ? (acc_i.addr + hseg.offs) : acc_i.addr; // [R8]
    inb = mem_ok(paddr, 1'b1); // [R12]
    inp = mem_ok(paddr, test); // [R1] [R2] [R3]
    viol = acc_i.req && (!inb || !inp ||
           (user && (!hit || !rt_ok(hseg.rights, acc_i.kind)))); // [R4] [R7] [R13]
    nxt_st.mem.kind = acc_i.kind;
    nxt_st.mem.addr = paddr;
    if (user && acc_i.req && acc_i.kind == ACC_EX && !viol) begin
      nxt_st.code_rt = hseg.prt;
    end
    // mode transitions
    if (bt) begin // [R23]
      if (test_avail_i) begin
        nxt_st.kind = SMK_TEST;
      end else begin
        nxt_st.ssm = 1'b0;
        nxt_st.sm = 1'b1;
        nxt_st.kind = SMK_APP;
      end
    end else if (ev_i.exc) begin // [R19]
      nxt_st.sav = {st_ff.ssm, st_ff.sm};
      nxt_st.sm = 1'b1;
    end else if (ev_i.irq) begin // [R19]
      nxt_st.sav = {st_ff.ssm, st_ff.sm};
      nxt_st.irq_act = 1'b1;
      if (!st_ff.irq_user) begin
        nxt_st.sm = 1'b1;
      end
    end else if (ev_i.sysvec) begin // [R17]
      if (user) begin
        nxt_st.sav = {st_ff.ssm, st_ff.sm};
        nxt_st.sm = 1'b1;
      end else begin
        vexc = 1'b1;
      end
    end else if (ev_i.cfgvec) begin // [R18]
      if (!PLAIN_CONFIG_ENTRY_VECTOR) begin
        nxt_st.sav = {st_ff.ssm, st_ff.sm};
        nxt_st.ssm = 1'b1;
        nxt_st.kind = SMK_APP;
      end
    end else if (ev_i.interrupt_return_instr) begin // [R20]
      if (user && !(st_ff.irq_user && st_ff.irq_act)) begin
        vexc = 1'b1;
      end else begin
        nxt_st.ssm = st_ff.sav[1];
        nxt_st.sm = st_ff.sav[0];
        nxt_st.irq_act = 1'b0;
      end
    end else if (ev_i.ucall) begin // [R21]
      if (sysm) begin
        nxt_st.sm = 1'b0;
      end
    end else if (sfr_i.wr && sfr_i.sel == SEL_MODE) begin // [R22]
      nxt_st.ssm = st_ff.ssm & sfr_i.data[MB_SSM];
      nxt_st.sm = st_ff.sm & sfr_i.data[MB_SM];
    end
    if (!nxt_st.ssm && st_ff.kind == SMK_BOOT) begin // [R23]
      nxt_st.kind = SMK_APP;
    end
    nxt_st.exc = viol || vexc; // [R13]
    nxt_st.mem.req = acc_i.req && !viol && !vexc; // [R24]
    // segment table writes
    if (seg_wr_i && sysm && int'(seg_idx_i) < NSEG) begin // [R4]
      nxt_st.tab[seg_idx_i] = seg_data_i;
    end
    // register access
    bi = bank_idx(st_ff.ssm, st_ff.sm); // [R15]
    wok = 1'b0;
    rok = 1'b0;
    rval = SFR_FIXED;
    unique case (sfr_i.sel)
      SEL_BANK: begin
        wok = 1'b1;
        rok = 1'b1;
        rval = st_ff.bank[bi];
      end
      SEL_APP_LO: begin
        wok = !user && !appm; // [R11]
        rok = !user;
        rval = st_ff.app_rt[7:0];
      end
      SEL_APP_HI: begin
        wok = !user && !appm; // [R11]
        rok = !user;
        rval = st_ff.app_rt[15:8];
      end
      SEL_IRQCFG: begin
        wok = sysm; // [R19]
        rok = !user;
        rval = {7'h00, st_ff.irq_user};
      end
      SEL_MODE: begin
        rok = 1'b1;
        rval = {6'h00, st_ff.ssm, st_ff.sm};
      end
      default: rval = SFR_FIXED;
    endcase
    if (sfr_i.wr && wok) begin // [R14]
      unique case (sfr_i.sel)
        SEL_BANK: nxt_st.bank[bi] = sfr_i.data; // [R15]
        SEL_APP_LO: nxt_st.app_rt[7:0] = sfr_i.data;
        SEL_APP_HI: nxt_st.app_rt[15:8] = sfr_i.data;
        SEL_IRQCFG: nxt_st.irq_user = sfr_i.data[IC_USER];
        default: nxt_st.irq_user = st_ff.irq_user;
      endcase
    end
    nxt_st.rvalid = sfr_i.rd;
    nxt_st.rdata = (sfr_i.rd && rok) ? rval : SFR_FIXED; // [R14]
    // peripheral group rights
    if (user) begin // [R9]
      nxt_st.grp = nxt_st.code_rt;
    end else if (appm) begin // [R11]
      nxt_st.grp = st_ff.app_rt;
    end else begin // [R10]
      nxt_st.grp = GRP_FULL;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
      st_ff.ssm <= 1'b1;
      st_ff.grp <= GRP_FULL;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign exc_o = st_ff.exc;
  assign mem_o = st_ff.mem;
  assign grp_rights_o = st_ff.grp;
  assign mode_word_o = {st_ff.ssm, st_ff.sm};
  assign super_kind_o = st_ff.kind;
  assign sfr_rdata_o = st_ff.rdata;
  assign sfr_rvalid_o = st_ff.rvalid;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  property p_supp;
    exc_o |-> !mem_o.req;
  endproperty
  a_supp: assert property (p_supp) else $error("access passed with exception"); // [R24]
  property p_user_miss;
    ce_i && acc_i.req && user && !hit |=> exc_o && !mem_o.req;
  endproperty
  a_user_miss: assert property (p_user_miss) else $error("user miss not trapped"); // [R13]
  property p_bound;
    ce_i && acc_i.req && !inb |=> exc_o;
  endproperty
  a_bound: assert property (p_bound) else $error("out of range not trapped"); // [R12]
  property p_test;
    ce_i && acc_i.req && test && inb && !ev_i.sysvec
      |=> mem_o.req && mem_o.addr == $past(acc_i.addr);
  endproperty
  a_test: assert property (p_test) else $error("test access refused"); // [R2]
  property p_full;
    ce_i && !user && !appm |=> grp_rights_o == GRP_FULL;
  endproperty
  a_full: assert property (p_full) else $error("group rights not full"); // [R10]
  property p_clr;
    ce_i && sfr_i.wr && sfr_i.sel == SEL_MODE && ev_i == '0 && !bt
      |=> (mode_word_o & ~$past(mode_word_o)) == 2'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("mode bit set by write"); // [R22]
  property p_system_entry_vector;
    ce_i && ev_i.sysvec && !ev_i.exc && !ev_i.irq && !bt && !user |=> exc_o;
  endproperty
  a_system_entry_vector: assert property (p_system_entry_vector) else $error("illegal vector not trapped"); // [R17]
  property p_ucall;
    ce_i && sysm && ev_i.ucall && !(ev_i.sysvec || ev_i.cfgvec || ev_i.exc ||
      ev_i.irq || ev_i.interrupt_return_instr) |=> mode_word_o == 2'h0 ##1 (user || $past(ev_i) != '0);
  endproperty
  a_ucall: assert property (p_ucall) else $error("user entry failed"); // [R21]
  property p_noboot;
    super_kind_o != SMK_BOOT |=> super_kind_o != SMK_BOOT;
  endproperty
  a_noboot: assert property (p_noboot) else $error("boot re-entered"); // [R23]
  property p_segwr;
    ce_i && seg_wr_i && !sysm |=> st_ff.tab == $past(st_ff.tab);
  endproperty
  a_segwr: assert property (p_segwr) else $error("segment write outside system"); // [R4]
  property p_fixrd;
    ce_i && sfr_i.rd && user && sfr_i.sel == SEL_APP_LO |=> sfr_rdata_o == SFR_FIXED;
  endproperty
  a_fixrd: assert property (p_fixrd) else $error("forbidden read leaked"); // [R14]

  c_user_ok: cover property (ce_i && acc_i.req && user && !viol ##1 mem_o.req);
  c_system_entry_vector: cover property (ce_i && ev_i.sysvec && user ##1 mode_word_o == 2'h1);
  c_interrupt_return_instr: cover property (ce_i && ev_i.interrupt_return_instr && st_ff.irq_act);

endmodule : mpac_mmu

// [pkg/mpac_pkg.sv]
// constants and carrier types of the memory protection and privilege block
package mpac_pkg;

  // ------------------------------------------------------------
  // widths and limits
  // ------------------------------------------------------------
  localparam int          AW       = 24;
  localparam int          NGRP     = 16;
  localparam int          NSEG_MAX = 64;
  localparam logic [23:0] USER_ENTRY = 24'h800000;

  // ------------------------------------------------------------
  // fixed partition: low part reserved, high part reachable
  // ------------------------------------------------------------
  localparam logic [23:0] RAM_LO = 24'h000000;
  localparam logic [23:0] RAM_MID = 24'h000800;
  localparam logic [23:0] RAM_HI = 24'h001000;
  localparam logic [23:0] EE_LO = 24'h100000;
  localparam logic [23:0] EE_MID = 24'h108000;
  localparam logic [23:0] EE_HI = 24'h110000;
  localparam logic [23:0] ROM_LO = 24'h200000;
  localparam logic [23:0] ROM_MID = 24'h210000;
  localparam logic [23:0] ROM_HI = 24'h220000;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int          RT_R = 0;
  localparam int          RT_W = 1;
  localparam int          RT_X = 2;
  localparam int          RT_END = 3;
  localparam int          MB_SM = 0;
  localparam int          MB_SSM = 1;
  localparam int          IC_USER = 0;
  localparam logic [3:0]  RT_UNUSED = 4'h0;
  localparam logic [7:0]  SFR_FIXED = 8'h00;
  localparam logic [15:0] GRP_FULL = 16'hFFFF;

  // ------------------------------------------------------------
  // enumerations and carriers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ACC_RD = 2'h0, ACC_WR = 2'h1, ACC_EX = 2'h2} mpac_kind_t;
  typedef enum logic [1:0] {SMK_BOOT = 2'h0, SMK_TEST = 2'h1, SMK_APP = 2'h2} mpac_smode_t;
  typedef enum logic [2:0] {
    SEL_BANK = 3'h0, SEL_APP_LO = 3'h1, SEL_APP_HI = 3'h2, SEL_IRQCFG = 3'h3, SEL_MODE = 3'h4
  } mpac_sel_t;

  typedef struct packed {
    logic [3:0]  rights;
    logic [23:0] vstart;
    logic [23:0] vend;
    logic [23:0] offs;
    logic [15:0] prt;
  } mpac_seg_t;

  typedef struct packed {
    logic        req;
    mpac_kind_t  kind;
    logic [23:0] addr;
  } mpac_acc_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    mpac_sel_t  sel;
    logic [7:0] data;
  } mpac_sfr_t;

  typedef struct packed {
    logic sysvec;
    logic cfgvec;
    logic exc;
    logic irq;
    logic interrupt_return_instr;
    logic ucall;
  } mpac_ev_t;

endpackage : mpac_pkg

// [verification/mpac_cpu_model.sv]
// cpu core model issuing virtual accesses and mode events
`timescale 1ns/1ns
module mpac_cpu_model
  import mpac_pkg::*;
(
  input  wire logic mclk_i,
  output mpac_acc_t acc_o,
  output mpac_ev_t  ev_o
);
  initial begin
    acc_o = '0;
    ev_o  = '0;
  end

  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  // one access held for one cycle; released address lines flip
  task automatic issue_acc(input mpac_kind_t kind, input logic [23:0] addr);
    @(posedge mclk_i);
    acc_o <= '{req: 1'b1, kind: kind, addr: addr};
    @(posedge mclk_i);
    acc_o <= '{req: 1'b0, kind: kind, addr: ~addr};
    #1;
  endtask : issue_acc

  // one event pulse, one cycle wide
  task automatic issue_ev(input mpac_ev_t ev);
    @(posedge mclk_i);
    ev_o <= ev;
    @(posedge mclk_i);
    ev_o <= '0;
    #1;
  endtask : issue_ev
endmodule : mpac_cpu_model

// [verification/mpac_mmu_tb_top.sv]
// self-checking testbench of the memory protection and privilege block
`timescale 1ns/1ns
module mpac_mmu_tb_top
  import mpac_pkg::*;
;
  logic            mclk_i       = 1'b0;
  logic            reset_n_i;
  logic            ce_i;
  logic            test_avail_i;
  logic            boot_done_i;
  logic            seg_wr_i;
  logic [5:0]      seg_idx_i;
  mpac_seg_t       seg_data_i;
  mpac_sfr_t       sfr_i;
  logic [1:0]      plain_mode;
  mpac_acc_t       acc_i;
  mpac_acc_t       mem_o;
  mpac_ev_t        ev_i;
  logic            exc_o;
  logic            sfr_rvalid_o;
  logic [NGRP-1:0] grp_rights_o;
  logic [1:0]      mode_word_o;
  mpac_smode_t     super_kind_o;
  logic [7:0]      sfr_rdata_o;
  int              failures     = 0;
  int              tests_run    = 0;

  always #50 mclk_i = ~mclk_i;

  mpac_cpu_model cpu (.mclk_i(mclk_i), .acc_o(acc_i), .ev_o(ev_i));

  mpac_mmu #(.PLAIN_CONFIG_ENTRY_VECTOR(1'b1)) DUT_PLAIN (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .test_avail_i(test_avail_i),
    .boot_done_i(boot_done_i), .ev_i(ev_i), .acc_i(acc_i), .seg_wr_i(seg_wr_i),
    .seg_idx_i(seg_idx_i), .seg_data_i(seg_data_i), .sfr_i(sfr_i), .exc_o(),
    .mem_o(), .grp_rights_o(), .mode_word_o(plain_mode),
    .super_kind_o(), .sfr_rdata_o(), .sfr_rvalid_o()
  );

  mpac_mmu DUT (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .test_avail_i(test_avail_i),
    .boot_done_i(boot_done_i), .ev_i(ev_i), .acc_i(acc_i), .seg_wr_i(seg_wr_i),
    .seg_idx_i(seg_idx_i), .seg_data_i(seg_data_i), .sfr_i(sfr_i), .exc_o(exc_o),
    .mem_o(mem_o), .grp_rights_o(grp_rights_o), .mode_word_o(mode_word_o),
    .super_kind_o(super_kind_o), .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic do_reset;
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    #1;
  endtask : do_reset

  task automatic boot_exit;
    @(posedge mclk_i);
    boot_done_i <= 1'b1;
    @(posedge mclk_i);
    boot_done_i <= 1'b0;
    #1;
  endtask : boot_exit

  task automatic sfr_op(input logic wr, input logic [2:0] sel, input logic [7:0] data);
    @(posedge mclk_i);
    sfr_i <= '{wr: wr, rd: ~wr, sel: mpac_sel_t'(sel), data: data};
    @(posedge mclk_i);
    sfr_i <= '0;
    #1;
  endtask : sfr_op

  task automatic seg_put(input logic [5:0] idx, input mpac_seg_t s);
    @(posedge mclk_i);
    seg_wr_i   <= 1'b1;
    seg_idx_i  <= idx;
    seg_data_i <= s;
    @(posedge mclk_i);
    seg_wr_i <= 1'b0;
    #1;
  endtask : seg_put

  task automatic acc_chk(input mpac_kind_t k, input logic [23:0] va, input logic e,
                         input logic [23:0] pa);
    cpu.issue_acc(k, va);
    chk(exc_o, e);
    chk(mem_o.req, !e);
    if (!e) chk(mem_o.addr, pa);
    if (!e) chk(mem_o.kind, k);
  endtask : acc_chk

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic sc_boot;
    chk(mode_word_o, 2'h2);
    chk(super_kind_o, SMK_BOOT);
    chk(grp_rights_o, GRP_FULL);
    boot_exit();
    chk(mode_word_o, 2'h1);
    boot_exit();
    chk(mode_word_o, 2'h1);
  endtask : sc_boot

  task automatic sc_part;
    logic [23:0] va [6] = '{24'h000100, 24'h000900, 24'h100000,
                            24'h10FFFF, 24'h210000, 24'h300000};
    logic [5:0]  bad    = 6'h25;
    for (int i = 0; i < 6; i++) begin
      acc_chk(ACC_RD, va[i], bad[i], va[i]);
    end
    cpu.issue_ev(6'h20);
    chk(exc_o, 1'b1);
    chk(mode_word_o, 2'h1);
    chk(grp_rights_o, GRP_FULL);
  endtask : sc_part

  task automatic sc_user;
    mpac_seg_t s = '{rights: 4'h5, vstart: 24'h000000, vend: 24'h0000FF,
                     offs: 24'h000900, prt: 16'h00A5};
    sfr_op(1'b1, 3'h0, 8'h11);
    sfr_op(1'b1, 3'h1, 8'h3C);
    sfr_op(1'b1, 3'h2, 8'hC3);
    seg_put(6'h00, s);
    seg_put(6'h01, mpac_seg_t'{rights: 4'h8, default: '0});
    seg_put(6'h02, mpac_seg_t'{rights: 4'h1, vstart: 24'h000200, vend: 24'h0002FF,
                               offs: 24'h000900, prt: 16'h0000});
    cpu.issue_ev(6'h01);
    chk(mode_word_o, 2'h0);
    acc_chk(ACC_RD, 24'h000010, 1'b0, 24'h000910);
    acc_chk(ACC_WR, 24'h000010, 1'b1, 24'h000000);
    acc_chk(ACC_EX, 24'h000020, 1'b0, 24'h000920);
    @(posedge mclk_i);
    #1;
    chk(grp_rights_o, 16'h00A5);
    acc_chk(ACC_RD, 24'h000200, 1'b1, 24'h000000);
    s.rights = 4'h7;
    seg_put(6'h00, s);
    acc_chk(ACC_WR, 24'h000010, 1'b1, 24'h000000);
    sfr_op(1'b1, 3'h0, 8'h22);
    sfr_op(1'b0, 3'h0, 8'h00);
    chk(sfr_rdata_o, 8'h22);
    chk(sfr_rvalid_o, 1'b1);
    sfr_op(1'b0, 3'h3, 8'h00);
    chk(sfr_rdata_o, SFR_FIXED);
    sfr_op(1'b1, 3'h4, 8'hFF);
    chk(mode_word_o, 2'h0);
    chk(sfr_rvalid_o, 1'b0);
    cpu.issue_ev(6'h02);
    chk(exc_o, 1'b1);
    cpu.issue_ev(6'h20);
    chk(mode_word_o, 2'h1);
    sfr_op(1'b0, 3'h0, 8'h00);
    chk(sfr_rdata_o, 8'h11);
    sfr_op(1'b0, 3'h5, 8'h00);
    chk(sfr_rdata_o, SFR_FIXED);
    cpu.issue_ev(6'h01);
    cpu.issue_ev(6'h08);
    chk(mode_word_o, 2'h1);
  endtask : sc_user

  task automatic sc_app;
    cpu.issue_ev(6'h10);
    chk(mode_word_o[1], 1'b1);
    chk(plain_mode, 2'h1);
    sfr_op(1'b1, 3'h4, 8'h02);
    chk(mode_word_o, 2'h2);
    chk(super_kind_o, SMK_APP);
    @(posedge mclk_i);
    #1;
    chk(grp_rights_o, 16'hC33C);
    sfr_op(1'b1, 3'h1, 8'h00);
    sfr_op(1'b0, 3'h1, 8'h00);
    chk(sfr_rdata_o, 8'h3C);
    cpu.issue_ev(6'h02);
    chk(mode_word_o, 2'h1);
    sfr_op(1'b1, 3'h3, 8'h01);
    sfr_op(1'b0, 3'h3, 8'h00);
    chk(sfr_rdata_o, 8'h01);
    cpu.issue_ev(6'h01);
    cpu.issue_ev(6'h04);
    chk(mode_word_o, 2'h0);
    cpu.issue_ev(6'h02);
    chk(exc_o, 1'b0);
    cpu.issue_ev(6'h02);
    chk(exc_o, 1'b1);
    cpu.issue_ev(6'h20);
    sfr_op(1'b1, 3'h3, 8'h00);
    cpu.issue_ev(6'h01);
    cpu.issue_ev(6'h04);
    chk(mode_word_o, 2'h1);
    cpu.issue_ev(6'h02);
    chk(mode_word_o, 2'h0);
  endtask : sc_app

  task automatic sc_test;
    @(posedge mclk_i);
    test_avail_i <= 1'b1;
    do_reset();
    boot_exit();
    chk(super_kind_o, SMK_TEST);
    chk(mode_word_o, 2'h2);
    acc_chk(ACC_RD, 24'h000100, 1'b0, 24'h000100);
    chk(grp_rights_o, GRP_FULL);
    @(posedge mclk_i);
    ce_i <= 1'b0;
    cpu.issue_ev(6'h10);
    cpu.issue_acc(ACC_RD, 24'h000900);
    chk(super_kind_o, SMK_TEST);
    chk(mem_o.req, 1'b0);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    #1;
  endtask : sc_test

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    reset_n_i    <= 1'b0;
    ce_i         <= 1'b1;
    test_avail_i <= 1'b0;
    boot_done_i  <= 1'b0;
    seg_wr_i     <= 1'b0;
    seg_idx_i    <= 6'h00;
    seg_data_i   <= '0;
    sfr_i        <= '0;
    do_reset();
    sc_boot();
    sc_part();
    sc_user();
    sc_app();
    sc_test();
    close_out();
  end

  initial begin
    repeat (2000) @(posedge mclk_i);
    failures++;
    close_out();
  end
endmodule : mpac_mmu_tb_top
